/* rtl/csd_pkg.sv */
// Package for the chip-select option decode block.
// Holds register offsets, field positions, reset values, field codes,
// the controller states and the carrier struct for one bus cycle.
// Assumes a single system clock and a classic Wishbone register slave.
package csd_pkg;

  // Register byte offsets on the register bus.
  localparam logic [4:0] CSD_OFS_OPTIONS = 5'h00;
  localparam logic [4:0] CSD_OFS_BASE = 5'h04;
  localparam logic [4:0] CSD_OFS_LATCH = 5'h08;
  localparam logic [4:0] CSD_OFS_PIN_ASSIGN = 5'h0c;
  localparam logic [4:0] CSD_OFS_STATUS = 5'h10;

  // Reset values.
  localparam logic [15:0] CSD_RST_OPTIONS = 16'h0000;
  localparam logic [15:0] CSD_RST_BASE = 16'h0007;
  localparam logic [6:0] CSD_RST_LATCH = 7'h7f;
  localparam logic [1:0] CSD_RST_PIN_ASSIGN = 2'h0;

  // Option register field positions.
  localparam int CSD_OPT_MODE = 15;
  localparam int CSD_OPT_BYTE_LO = 13;
  localparam int CSD_OPT_DIR_LO = 11;
  localparam int CSD_OPT_STROBE_SELECT = 10;
  localparam int CSD_OPT_ACK_LO = 6;
  localparam int CSD_OPT_SPACE_LO = 4;
  localparam int CSD_OPT_LEVEL_LO = 1;
  localparam int CSD_OPT_AUTOVECTOR_REQUEST = 0;

  // Base register: address bits 23..11 sit in 15..3, block size in 2..0.
  localparam int CSD_BASE_ADDR_LO = 3;

  // Field codes.
  localparam logic [1:0] CSD_BYTE_LOWER = 2'h1;
  localparam logic [1:0] CSD_BYTE_UPPER = 2'h2;
  localparam logic [1:0] CSD_BYTE_BOTH = 2'h3;
  localparam logic [1:0] CSD_DIR_READ = 2'h1;
  localparam logic [1:0] CSD_DIR_WRITE = 2'h2;
  localparam logic [1:0] CSD_DIR_BOTH = 2'h3;
  localparam logic [1:0] CSD_SPACE_CPU = 2'h0;
  localparam logic [1:0] CSD_SPACE_USER = 2'h1;
  localparam logic [1:0] CSD_SPACE_SUPER = 2'h2;
  localparam logic [1:0] CSD_SPACE_ANY = 2'h3;
  localparam logic [2:0] CSD_LEVEL_ANY = 3'h0;
  localparam logic [3:0] CSD_ACK_MAX_WAIT = 4'hd;
  localparam logic [3:0] CSD_ACK_FAST = 4'he;
  localparam logic [3:0] CSD_ACK_EXTERNAL = 4'hf;

  // Pin assignment codes.
  localparam logic [1:0] CSD_PIN_DISCRETE = 2'h0;
  localparam logic [1:0] CSD_PIN_PORT8 = 2'h1;
  localparam logic [1:0] CSD_PIN_PORT16 = 2'h2;

  typedef enum logic [2:0] {
    CSD_ST_IDLE = 3'b000,
    CSD_ST_COUNT = 3'b001,
    CSD_ST_EXT = 3'b010,
    CSD_ST_HOLD = 3'b011,
    CSD_ST_SYNC_WAIT = 3'b100,
    CSD_ST_SYNC_ACTIVE = 3'b101
  } csd_state_t;

  // One bus cycle as the internal bus presents it; all levels on clk.
  typedef struct packed {
    logic [23:0] addr;
    logic read;
    logic cpu_space;
    logic supervisor;
    logic iack;
    logic upper_lane;
    logic lower_lane;
    logic address_strobe_n;
    logic data_strobe_n;
  } csd_cycle_t;

endpackage

/* rtl/csd_chip_select.sv */
// One chip-select channel: base-address match, option qualification,
// internal or external termination, autovector and the discrete latch.
// Assumes the bus cycle and the slow bus clock level arrive on clk_sys_i,
// and that the external acknowledge pin is asynchronous to it.
`timescale 1ns/1ps
`default_nettype none

module csd_chip_select
  import csd_pkg::*;
#(
  parameter int LATCH_BIT = 0
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire csd_cycle_t cycle_i,
  input wire logic slow_bus_clock_i,
  input wire logic wait_ack_ext_n_i,
  output logic chip_select_n_o,
  output logic wait_ack_source_n_o,
  output logic autovector_request_n_o,
  output logic slow_cycle_pending_o,
  output logic [7:0] discrete_output_latch_o
);

  logic [15:0] options_reg;
  logic [15:0] base_reg;
  logic [6:0] latch_reg;
  logic [1:0] pin_assign_reg;
  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;
  csd_state_t state_reg;
  logic [3:0] count_reg;
  logic cs_n_reg;
  logic ack_n_reg;
  logic autovector_request_n_reg;
  logic pending_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  logic ext_ack_n_reg;
  logic slow_clk_prev_reg;

  // Option fields.
  logic opt_sync;
  logic [1:0] opt_byte;
  logic [1:0] opt_dir;
  logic opt_strobe_select;
  logic [3:0] opt_ack;
  logic [1:0] opt_space;
  logic [2:0] opt_level;
  logic opt_autovector_request;

  assign opt_sync = options_reg[CSD_OPT_MODE];
  assign opt_byte = options_reg[CSD_OPT_BYTE_LO +: 2];
  assign opt_dir = options_reg[CSD_OPT_DIR_LO +: 2];
  assign opt_strobe_select = options_reg[CSD_OPT_STROBE_SELECT];
  assign opt_ack = options_reg[CSD_OPT_ACK_LO +: 4];
  assign opt_space = options_reg[CSD_OPT_SPACE_LO +: 2];
  assign opt_level = options_reg[CSD_OPT_LEVEL_LO +: 3];
  assign opt_autovector_request = options_reg[CSD_OPT_AUTOVECTOR_REQUEST];

  // Base match over the bits that the block size leaves significant.
  logic [12:0] cmp_mask;
  logic base_match;

  always_comb begin
    case (base_reg[2:0])
      3'h0: cmp_mask = 13'h1fff;
      3'h1: cmp_mask = 13'h1ffc;
      3'h2: cmp_mask = 13'h1ff8;
      3'h3: cmp_mask = 13'h1fe0;
      3'h4: cmp_mask = 13'h1fc0;
      3'h5: cmp_mask = 13'h1f80;
      3'h6: cmp_mask = 13'h1f00;
      default: cmp_mask = 13'h1e00;
    endcase
  end

  assign base_match = ((cycle_i.addr[23:11] ^ base_reg[15:CSD_BASE_ADDR_LO])
                       & cmp_mask) == 13'h0000;

  // Option qualification.
  logic dir_ok;
  logic byte_ok;
  logic space_ok;
  logic level_ok;
  logic qualified;
  logic strobe_active;

  always_comb begin
    case (opt_dir)
      CSD_DIR_READ: dir_ok = cycle_i.read;
      CSD_DIR_WRITE: dir_ok = !cycle_i.read;
      CSD_DIR_BOTH: dir_ok = 1'b1;
      default: dir_ok = 1'b0;
    endcase
  end

  always_comb begin
    if (pin_assign_reg != CSD_PIN_PORT16) begin
      byte_ok = 1'b1;
    end else begin
      case (opt_byte)
        CSD_BYTE_LOWER: byte_ok = cycle_i.lower_lane;
        CSD_BYTE_UPPER: byte_ok = cycle_i.upper_lane;
        CSD_BYTE_BOTH: byte_ok = cycle_i.lower_lane | cycle_i.upper_lane;
        default: byte_ok = 1'b0;
      endcase
    end
  end

  // The level compare feeds only this select; interrupt recognition by
  // the processor never sees it.
  assign level_ok = (opt_level == CSD_LEVEL_ANY) ||
                    (opt_level == cycle_i.addr[3:1]);

  always_comb begin
    case (opt_space)
      CSD_SPACE_CPU: space_ok = cycle_i.cpu_space & cycle_i.iack
                                & level_ok;
      CSD_SPACE_USER: space_ok = !cycle_i.cpu_space & !cycle_i.supervisor;
      CSD_SPACE_SUPER: space_ok = !cycle_i.cpu_space & cycle_i.supervisor;
      default: space_ok = !cycle_i.cpu_space;
    endcase
  end

  // A pin used as a discrete output never acts as a chip select.
  assign qualified = base_match & dir_ok & byte_ok & space_ok
                     & (pin_assign_reg != CSD_PIN_DISCRETE);

  assign strobe_active = opt_strobe_select ? !cycle_i.data_strobe_n
                                  : !cycle_i.address_strobe_n;

  logic autovector_hit;
  assign autovector_hit = (opt_space == CSD_SPACE_CPU) & opt_autovector_request;

  // External acknowledge pin: three stages, a change counts once the
  // second and third stages agree.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      ext_s3_reg <= 1'b1;
      ext_ack_n_reg <= 1'b1;
    end else begin
      ext_s1_reg <= wait_ack_ext_n_i;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      if (ext_s2_reg == ext_s3_reg) begin
        ext_ack_n_reg <= ext_s3_reg;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      slow_clk_prev_reg <= 1'b0;
    end else begin
      slow_clk_prev_reg <= slow_bus_clock_i;
    end
  end

  logic slow_rise;
  logic slow_fall;
  assign slow_rise = slow_bus_clock_i & !slow_clk_prev_reg;
  assign slow_fall = !slow_bus_clock_i & slow_clk_prev_reg;

  // Select controller. Once asserted, the select stays on until the
  // strobe goes away so that a slow device never sees it drop mid-access.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_reg <= CSD_ST_IDLE;
      count_reg <= 4'h0;
      cs_n_reg <= 1'b1;
      ack_n_reg <= 1'b1;
      autovector_request_n_reg <= 1'b1;
      pending_reg <= 1'b0;
    end else begin
      case (state_reg)
        CSD_ST_IDLE: begin
          ack_n_reg <= 1'b1;
          autovector_request_n_reg <= 1'b1;
          if (qualified && opt_sync) begin
            // The acknowledge field plays no part from here on.
            pending_reg <= 1'b1;
            state_reg <= CSD_ST_SYNC_WAIT;
          end else if (qualified && strobe_active) begin
            cs_n_reg <= 1'b0;
            if (opt_ack == CSD_ACK_FAST) begin
              ack_n_reg <= autovector_hit;
              autovector_request_n_reg <= !autovector_hit;
              state_reg <= CSD_ST_HOLD;
            end else if (opt_ack == CSD_ACK_EXTERNAL) begin
              state_reg <= CSD_ST_EXT;
            end else begin
              count_reg <= opt_ack;
              state_reg <= CSD_ST_COUNT;
            end
          end
        end
        CSD_ST_COUNT: begin
          if (!strobe_active) begin
            cs_n_reg <= 1'b1;
            state_reg <= CSD_ST_IDLE;
          end else if (count_reg == 4'h0) begin
            ack_n_reg <= autovector_hit;
            autovector_request_n_reg <= !autovector_hit;
            state_reg <= CSD_ST_HOLD;
          end else begin
            count_reg <= count_reg - 4'h1;
          end
        end
        CSD_ST_EXT: begin
          // The external device ends the cycle with its own acknowledge.
          if (!strobe_active) begin
            cs_n_reg <= 1'b1;
            state_reg <= CSD_ST_IDLE;
          end else if (!ext_ack_n_reg) begin
            autovector_request_n_reg <= !autovector_hit;
            state_reg <= CSD_ST_HOLD;
          end
        end
        CSD_ST_HOLD: begin
          if (!strobe_active) begin
            cs_n_reg <= 1'b1;
            ack_n_reg <= 1'b1;
            autovector_request_n_reg <= 1'b1;
            state_reg <= CSD_ST_IDLE;
          end
        end
        CSD_ST_SYNC_WAIT: begin
          if (!qualified) begin
            pending_reg <= 1'b0;
            state_reg <= CSD_ST_IDLE;
          end else if (slow_rise) begin
            cs_n_reg <= 1'b0;
            state_reg <= CSD_ST_SYNC_ACTIVE;
          end
        end
        CSD_ST_SYNC_ACTIVE: begin
          if (slow_fall) begin
            // Autovector here has variable timing; software avoids it.
            ack_n_reg <= autovector_hit;
            autovector_request_n_reg <= !autovector_hit;
            pending_reg <= 1'b0;
            state_reg <= CSD_ST_HOLD;
          end
        end
        default: begin
          cs_n_reg <= 1'b1;
          ack_n_reg <= 1'b1;
          autovector_request_n_reg <= 1'b1;
          pending_reg <= 1'b0;
          state_reg <= CSD_ST_IDLE;
        end
      endcase
    end
  end

  // Pin: select in bus use, latch bit when assigned as discrete output.
  logic pin_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pin_reg <= 1'b1;
    end else if (pin_assign_reg == CSD_PIN_DISCRETE) begin
      pin_reg <= latch_reg[LATCH_BIT];
    end else begin
      pin_reg <= cs_n_reg;
    end
  end

  // Register bus: ack one cycle after the request, dropped the next.
  logic wb_req;
  logic wb_write;
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_write = wb_req & wb_we_i & wb_ack_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wb_ack_reg <= 1'b0;
    end else begin
      wb_ack_reg <= wb_req & !wb_ack_reg;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      options_reg <= CSD_RST_OPTIONS;
      base_reg <= CSD_RST_BASE;
      latch_reg <= CSD_RST_LATCH;
      pin_assign_reg <= CSD_RST_PIN_ASSIGN;
    end else if (wb_write) begin
      case (wb_adr_i)
        CSD_OFS_OPTIONS: begin
          if (wb_sel_i[0]) options_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) options_reg[15:8] <= wb_dat_i[15:8];
        end
        CSD_OFS_BASE: begin
          if (wb_sel_i[0]) base_reg[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) base_reg[15:8] <= wb_dat_i[15:8];
        end
        CSD_OFS_LATCH: begin
          if (wb_sel_i[0]) latch_reg <= wb_dat_i[6:0];
        end
        CSD_OFS_PIN_ASSIGN: begin
          if (wb_sel_i[0]) pin_assign_reg <= wb_dat_i[1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wb_dat_reg <= 32'h0000_0000;
    end else if (wb_req && !wb_ack_reg && !wb_we_i) begin
      case (wb_adr_i)
        CSD_OFS_OPTIONS: wb_dat_reg <= {16'h0000, options_reg};
        CSD_OFS_BASE: wb_dat_reg <= {16'h0000, base_reg};
        CSD_OFS_LATCH: wb_dat_reg <= {25'h0000000, latch_reg};
        CSD_OFS_PIN_ASSIGN: wb_dat_reg <= {30'h00000000, pin_assign_reg};
        CSD_OFS_STATUS: wb_dat_reg <= {21'h000000, count_reg, pending_reg,
                                       autovector_request_n_reg, ack_n_reg, cs_n_reg,
                                       state_reg};
        default: wb_dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;
  assign chip_select_n_o = pin_reg;
  assign wait_ack_source_n_o = ack_n_reg;
  assign autovector_request_n_o = autovector_request_n_reg;
  assign slow_cycle_pending_o = pending_reg;
  assign discrete_output_latch_o = {1'b0, latch_reg};

endmodule

`default_nettype wire

/* testbench/csd_chip_select_sva.sv */
// Assertions on the ports of one chip-select channel.
// Assumes the one-cycle register answer and strobe release of the design.
`timescale 1ns/1ps
`default_nettype none
module csd_chip_select_chk
  import csd_pkg::*;
#(
  parameter int LATCH_BIT = 0
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire csd_cycle_t cycle_i,
  input wire logic slow_bus_clock_i,
  input wire logic wait_ack_ext_n_i,
  input wire logic chip_select_n_o,
  input wire logic wait_ack_source_n_o,
  input wire logic autovector_request_n_o,
  input wire logic slow_cycle_pending_o,
  input wire logic [7:0] discrete_output_latch_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  wire logic strobes_up = cycle_i.address_strobe_n & cycle_i.data_strobe_n;
  wire logic latch_hit = wb_ack_o && wb_adr_i == CSD_OFS_LATCH;
  wire logic term_low = !wait_ack_source_n_o || !autovector_request_n_o;

  property p_bus_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("no bus answer");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_bit7_zero;
    discrete_output_latch_o[7] == 1'b0;
  endproperty
  a_bit7_zero: assert property (p_bit7_zero)
    else $error("bit 7 set");
  property p_bit7_read;
    latch_hit && !wb_we_i |-> wb_dat_o[7] == 1'b0;
  endproperty
  a_bit7_read: assert property (p_bit7_read)
    else $error("bit 7 read");
  property p_latch_write;
    latch_hit && wb_we_i && wb_sel_i[0]
      |=> discrete_output_latch_o[6:0] == $past(wb_dat_i[6:0]);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("latch");
  property p_release;
    strobes_up [*2] |-> !term_low;
  endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_ack_cause;
    term_low |-> $past(!strobes_up);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("no strobe");
  property p_one_term;
    !(!wait_ack_source_n_o && !autovector_request_n_o);
  endproperty
  a_one_term: assert property (p_one_term) else $error("two ends");
  property p_pending_first;
    $rose(slow_cycle_pending_o) |-> chip_select_n_o;
  endproperty
  a_pending_first: assert property (p_pending_first)
    else $error("late");
endmodule

bind csd_chip_select csd_chip_select_chk #(.LATCH_BIT(LATCH_BIT)) u_chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cycle_i(cycle_i), .slow_bus_clock_i(slow_bus_clock_i),
  .wait_ack_ext_n_i(wait_ack_ext_n_i), .chip_select_n_o(chip_select_n_o),
  .wait_ack_source_n_o(wait_ack_source_n_o),
  .autovector_request_n_o(autovector_request_n_o),
  .slow_cycle_pending_o(slow_cycle_pending_o),
  .discrete_output_latch_o(discrete_output_latch_o));
`default_nettype wire

/* testbench/csd_ext_target.sv */
// Model of an external peripheral that ends its own cycles.
// Assumes it sees the chip-select pin on the system clock.
`timescale 1ns/1ps
`default_nettype none
module csd_ext_target #(
  parameter int ACK_DELAY = 2
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic chip_select_n_i,
  output logic wait_ack_ext_n_o
);
  int count_reg;
  // The pin is driven high in reset and while the select is high, so it reads high whenever the target is idle.
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || chip_select_n_i) begin
      count_reg <= 0;
      wait_ack_ext_n_o <= 1'b1;
    end else begin
      if (count_reg < ACK_DELAY) begin
        count_reg <= count_reg + 1;
      end
      wait_ack_ext_n_o <= (count_reg < ACK_DELAY);
    end
  end
endmodule
`default_nettype wire

/* testbench/test_csd_chip_select.sv */
// Self-checking bench for one chip-select channel.
// Assumes the design package, the external target model and the checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("mismatch at %0t: %h vs %h", $time, (got), (exp)); \
  end \
end
module test_csd_chip_select
  import csd_pkg::*;
;
  typedef struct packed {
    logic [15:0] opt;
    logic [15:0] base;
    logic [1:0] pin;
    logic [7:0] misc;
    logic [23:0] addr;
    logic [1:0] kind;
  } csd_row_t;
  // Kind: 0 no select, 1 internal ack, 2 autovector, 3 target acks.
  // Misc: read, cpu space, supervisor, iack, upper, lower, data strobe.
  csd_row_t rows [26] = '{
    {16'h7830, 16'h7, 2'h2, 8'hae, 24'h0, 2'h1},
    {16'h7870, 16'h7, 2'h2, 8'hae, 24'h0, 2'h1},
    {16'h7b70, 16'h7, 2'h2, 8'hae, 24'h0, 2'h1},
    {16'h7bb0, 16'h7, 2'h2, 8'hae, 24'h0, 2'h1},
    {16'h7bf0, 16'h7, 2'h2, 8'hae, 24'h0, 2'h3},
    {16'h7830, 16'h7, 2'h2, 8'hae, 24'h100000, 2'h0},
    {16'h7830, 16'h0, 2'h2, 8'hae, 24'h800, 2'h0},
    {16'h7830, 16'h8, 2'h2, 8'hae, 24'h800, 2'h1},
    {16'h1830, 16'h7, 2'h2, 8'hae, 24'h0, 2'h0},
    {16'h1830, 16'h7, 2'h1, 8'hae, 24'h0, 2'h1},
    {16'h3830, 16'h7, 2'h2, 8'haa, 24'h0, 2'h0},
    {16'h5830, 16'h7, 2'h2, 8'haa, 24'h0, 2'h1},
    {16'h6030, 16'h7, 2'h2, 8'hae, 24'h0, 2'h0},
    {16'h6830, 16'h7, 2'h2, 8'h2e, 24'h0, 2'h0},
    {16'h7030, 16'h7, 2'h2, 8'h2e, 24'h0, 2'h1},
    {16'h7c30, 16'h7, 2'h2, 8'hac, 24'h0, 2'h0},
    {16'h7c30, 16'h7, 2'h2, 8'hae, 24'h0, 2'h1},
    {16'h7830, 16'h7, 2'h2, 8'hac, 24'h0, 2'h1},
    {16'h7810, 16'h7, 2'h2, 8'hae, 24'h0, 2'h0},
    {16'h7810, 16'h7, 2'h2, 8'h8e, 24'h0, 2'h1},
    {16'h7806, 16'h7, 2'h2, 8'hfe, 24'h6, 2'h1},
    {16'h7806, 16'h7, 2'h2, 8'hfe, 24'h8, 2'h0},
    {16'h7807, 16'h7, 2'h2, 8'hfe, 24'h6, 2'h2},
    {16'h7800, 16'h7, 2'h2, 8'hfe, 24'h8, 2'h1},
    {16'hfbf0, 16'h7, 2'h2, 8'hae, 24'h0, 2'h1},
    {16'h7830, 16'h7, 2'h0, 8'hae, 24'h0, 2'h0}
  };
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [4:0] adr = 5'h0;
  logic [31:0] wdat = 32'h0;
  logic [2:0] div = 3'h0;
  csd_cycle_t bus = '1;
  logic [31:0] rdat, q;
  logic ack, cs_n, ackn, avn, pend, ext_n;
  logic [7:0] latch;
  csd_row_t r;
  int cs_t, ack_t, av_t, pd_t, n, cycles, miscompares, n_checks;
  // Strobe seen at the first edge, zero-wait answer launched at the second
  // and visible from the third, the same edge on which the pin goes low.
  localparam int ACK_OFS = 3;

  csd_chip_select u_csd_chip_select (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cycle_i(bus),
    .slow_bus_clock_i(div[2]), .wait_ack_ext_n_i(ext_n),
    .chip_select_n_o(cs_n), .wait_ack_source_n_o(ackn),
    .autovector_request_n_o(avn), .slow_cycle_pending_o(pend),
    .discrete_output_latch_o(latch));
  csd_ext_target u_csd_ext_target (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .chip_select_n_i(cs_n), .wait_ack_ext_n_o(ext_n));

  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    div <= div + 3'h1;
    cycles++;
    if (cycles > 6000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (miscompares == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_sys_i);
    while (ack !== 1'b1) @(posedge clk_sys_i);
    q = rdat;
    cyc <= 1'b0;
  endtask

  // Drives one strobed cycle and notes when each output first answers.
  task automatic access(input logic [7:0] m, input logic [23:0] a);
    @(posedge clk_sys_i);
    bus <= {a, m[7:2], 1'b0, ~m[1]};
    cs_t = -1;
    ack_t = -1;
    av_t = -1;
    pd_t = -1;
    for (int k = 1; k <= 24; k++) begin
      @(posedge clk_sys_i);
      if (cs_t < 0 && cs_n === 1'b0) cs_t = k;
      if (ack_t < 0 && ackn === 1'b0) ack_t = k;
      if (av_t < 0 && avn === 1'b0) av_t = k;
      if (pd_t < 0 && pend === 1'b1) pd_t = k;
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      wb(1'b1, CSD_OFS_OPTIONS, {16'h0, r.opt});
      wb(1'b1, CSD_OFS_BASE, {16'h0, r.base});
      wb(1'b1, CSD_OFS_PIN_ASSIGN, {30'h0, r.pin});
      access(r.misc, r.addr);
      n = r.opt[9:6];
      if (r.kind != 0 && !r.opt[15]) `CHK(cs_t, ACK_OFS)
      `CHK(cs_t >= 0, r.kind != 0)
      `CHK(pd_t >= 0, r.kind != 0 && r.opt[15])
      `CHK(av_t >= 0, r.kind == 2)
      `CHK(ack_t >= 0, r.kind == 1)
      if (r.kind == 1 && !r.opt[15] && n < 14) `CHK(ack_t, ACK_OFS + n)
      if (r.kind == 1 && n == 14) `CHK(ack_t < ACK_OFS, 1'b1)
      if (r.kind == 3) `CHK(cs_n, 1'b0)
      @(posedge clk_sys_i);
      bus <= '1;
      repeat (3) @(posedge clk_sys_i);
      `CHK(cs_n, 1'b1)
    end
    // A reset in mid-access must release the select, acknowledge, autovector and pending outputs and reload the latch within two edges.
    wb(1'b1, CSD_OFS_PIN_ASSIGN, 32'h2);
    wb(1'b1, CSD_OFS_OPTIONS, 32'h7b70);
    access(8'hae, 24'h0);
    `CHK(ack_t, ACK_OFS + 13)
    `CHK(cs_n, 1'b0)
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    `CHK({cs_n, ackn, avn, pend, latch}, {4'b1110, 8'h7f})
    bus <= '1;
    reset_n_i <= 1'b1;
    wb(1'b0, CSD_OFS_OPTIONS, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b0, CSD_OFS_BASE, 32'h0);
    `CHK(q, 32'h7)
    wb(1'b0, CSD_OFS_STATUS, 32'h0);
    `CHK(q, 32'h38)
    wb(1'b1, CSD_OFS_LATCH, 32'hff);
    wb(1'b0, CSD_OFS_LATCH, 32'h0);
    `CHK(q, 32'h7f)
    wb(1'b1, CSD_OFS_LATCH, 32'h7e);
    repeat (3) @(posedge clk_sys_i);
    `CHK({cs_n, latch}, 9'h07e)
    wb(1'b1, CSD_OFS_LATCH, 32'h01);
    repeat (3) @(posedge clk_sys_i);
    `CHK({cs_n, latch}, 9'h101)
    wb(1'b0, 5'h14, 32'h0);
    `CHK(q, 32'h0)
    end_of_test();
  end
endmodule
`default_nettype wire
